// ---- rtl/cmf_pkg.sv ----
package cmf_pkg;

    localparam int CMF_TX_SLOTS = 3;
    localparam int CMF_RX_FIFOS = 2;
    localparam int CMF_RX_DEPTH = 3;
    localparam int CMF_CNT_W    = 2;
    localparam int CMF_BANKS    = 14;
    localparam int CMF_NREGS    = 13;

    // Byte addresses on the bus
    localparam logic [7:0] CMF_OFF_TX0   = 8'h00;
    localparam logic [7:0] CMF_TX_END    = 8'h0C;
    localparam logic [7:0] CMF_OFF_RX0   = 8'h10;
    localparam logic [7:0] CMF_OFF_FCTRL = 8'h30;
    localparam logic [7:0] CMF_OFF_FMODE = 8'h34;

    // Register codes produced by the address decoder
    localparam logic [3:0] CMF_CODE_RX0   = 4'h3;
    localparam logic [3:0] CMF_CODE_FCTRL = 4'hB;
    localparam logic [3:0] CMF_CODE_FMODE = 4'hC;
    localparam logic [3:0] CMF_CODE_NONE  = 4'hF;

    localparam logic        CMF_FCS_RST    = 1'b1;
    localparam logic [13:0] CMF_FMODE_RST  = 14'h0000;
    localparam logic [30:0] CMF_FCTRL_RSVD = 31'h160E0700;
    localparam logic [31:0] CMF_TX_RST     = 32'h00000000;
    localparam logic [3:0]  CMF_MAX_LEN    = 4'h8;

    typedef enum logic {
        CMF_IDLE = 1'b0,
        CMF_ACK  = 1'b1
    } cmf_bus_e;

    // Message handed over by the protocol engine
    typedef struct packed {
        logic [10:0] std_id;
        logic [17:0] ext_id;
        logic        ide;
        logic        rtr;
        logic [3:0]  dlc;
        logic [7:0]  filt;
        logic [63:0] data;
    } cmf_rx_msg_s;

    // Message as stored in a receive FIFO
    typedef struct packed {
        logic [10:0] std_id;
        logic [17:0] ext_id;
        logic        ide;
        logic        rtr;
        logic [15:0] stamp;
        logic [7:0]  filt;
        logic [3:0]  len;
        logic [63:0] data;
    } cmf_rx_rec_s;

    typedef struct packed {
        logic [10:0] rx_standard_id;
        logic [17:0] rx_extended_id;
        logic        rx_id_format;
        logic        rx_frame_kind;
        logic        rsvd;
    } cmf_id_word_s;

    typedef struct packed {
        logic [15:0] rx_time_stamp;
        logic [7:0]  rx_matched_filter;
        logic [3:0]  rsvd;
        logic [3:0]  rx_length;
    } cmf_len_word_s;

    function automatic logic [3:0] cmf_decode(input logic [7:0] a);
        logic [7:0] r;
        r = a - CMF_OFF_RX0;
        if (a[1:0] != 2'b00)
            return CMF_CODE_NONE;
        if (a < CMF_OFF_RX0)
            return (a < CMF_TX_END) ? {2'b00, a[3:2]} : CMF_CODE_NONE;
        if (a < CMF_OFF_FCTRL)
            return 4'(CMF_CODE_RX0 + r[5:2]);
        if (a == CMF_OFF_FCTRL)
            return CMF_CODE_FCTRL;
        if (a == CMF_OFF_FMODE)
            return CMF_CODE_FMODE;
        return CMF_CODE_NONE;
    endfunction

endpackage

// ---- rtl/cmf_rx_fifo.sv ----
`timescale 1ns/1ps
module cmf_rx_fifo
    import cmf_pkg::*;
#(
    parameter int DEPTH = CMF_RX_DEPTH
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_n,
    input  wire logic                 i_push_valid,
    output logic                      o_push_ready,
    input  wire cmf_rx_rec_s          i_push_data,
    input  wire logic                 i_pop,
    output cmf_rx_rec_s               o_head,
    output logic [CMF_CNT_W-1:0]      o_count,
    output logic                      o_empty
);
    typedef logic [CMF_CNT_W-1:0] cmf_ptr_t;

    cmf_rx_rec_s mem [DEPTH];
    cmf_ptr_t    wr_ptr_reg;
    cmf_ptr_t    rd_ptr_reg;
    cmf_ptr_t    count_reg;
    logic        push;
    logic        pop;

    function automatic cmf_ptr_t cmf_wrap(input cmf_ptr_t p);
        return (p == cmf_ptr_t'(DEPTH - 1)) ? '0 : cmf_ptr_t'(p + 1'b1);
    endfunction

    assign o_push_ready = (count_reg != cmf_ptr_t'(DEPTH));
    assign o_empty      = (count_reg == '0);
    assign push         = i_push_valid & o_push_ready;
    assign pop          = i_pop & ~o_empty;
    assign o_head       = mem[rd_ptr_reg];
    assign o_count      = count_reg;

    always_ff @(posedge i_clk) begin
        if (push)
            mem[wr_ptr_reg] <= i_push_data;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push)
                wr_ptr_reg <= cmf_wrap(wr_ptr_reg);
            if (pop)
                rd_ptr_reg <= cmf_wrap(rd_ptr_reg);
            count_reg <= cmf_ptr_t'(count_reg + push - pop);
        end
    end
endmodule

// ---- rtl/cmf_tx_slot.sv ----
`timescale 1ns/1ps
module cmf_tx_slot
    import cmf_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_wr,
    input  wire logic [3:0]  i_sel,
    input  wire logic [31:0] i_dat,
    input  wire logic        i_empty,
    input  wire logic        i_stamp_on,
    input  wire logic [15:0] i_stamp,
    output logic [31:0]      o_word,
    output logic [31:0]      o_send
);
    logic [31:0] word_reg;
    logic [31:0] word_next;
    logic [31:0] send_reg;
    logic [31:0] send_next;
    logic        wr_ok;

    assign wr_ok = i_wr & i_empty;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign word_next[8*b +: 8] = (wr_ok && i_sel[b]) ?
                                     i_dat[8*b +: 8] : word_reg[8*b +: 8];
    end

    // Stamp low byte rides in byte 7, high byte in byte 6
    assign send_next = i_stamp_on ?
        {i_stamp[7:0], i_stamp[15:8], word_reg[15:0]} :
        word_reg;

    assign o_word = word_reg;
    assign o_send = send_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_reg <= CMF_TX_RST;
            send_reg <= CMF_TX_RST;
        end else begin
            word_reg <= word_next;
            send_reg <= send_next;
        end
    end
endmodule

// ---- rtl/cmf_regs.sv ----
// Summary of operation
// - Transmit upper data register takes writes only while mailbox empty.
// - Time-triggered with stamp enabled sends stamp bits 15:8 as data byte 6.
// - Receive data high word holds bytes 7,6,5,4 from top lane down.
// - Receive data low word holds bytes 3,2,1,0 from top lane down.
// - Receive mailbox registers are read-only; writes change nothing.
// - Identifier bits 31:21 hold standard id or upper eleven extended bits.
// - Identifier bits 20:3 hold lower eighteen extended identifier bits.
// - Identifier bit 2 gives format: zero standard, one extended.
// - Identifier bit 1 gives frame kind, one for remote; bit 0 zero.
// - Timer captured at frame start appears in length register bits 31:16.
// - Length register bits 15:8 give the accepting filter number.
// - Length register bits 3:0 give data length, zero to eight.
// - Remote frames always report data length zero.
// - Each receive FIFO holds three messages and shows only the oldest.
// - Filter configuration switch resets to one; one selects config mode.
// - Only software writes change the filter configuration switch.
// - Filter mode select accepts writes only while the switch is one.
// - Fourteen per-bank mode bits reset to zero; one selects list matching.
`timescale 1ns/1ps
module cmf_regs
    import cmf_pkg::*;
(
    input  wire logic                     I_CLK,
    input  wire logic                     I_RST_N,
    input  wire logic                     I_WB_CYC,
    input  wire logic                     I_WB_STB,
    input  wire logic                     I_WB_WE,
    input  wire logic [7:0]               I_WB_ADR,
    input  wire logic [3:0]               I_WB_SEL,
    input  wire logic [31:0]              I_WB_DAT,
    output logic [31:0]                   O_WB_DAT,
    output logic                          O_WB_ACK,
    input  wire logic [CMF_TX_SLOTS-1:0]  I_TX_EMPTY,
    input  wire logic                     I_TT_MODE,
    input  wire logic [CMF_TX_SLOTS-1:0]  I_TX_STAMP_EN,
    input  wire logic [CMF_TX_SLOTS-1:0][15:0] I_MSG_STAMP,
    output logic [CMF_TX_SLOTS-1:0][31:0] O_TX_DATA_HIGH,
    input  wire logic [15:0]              I_TIMER,
    input  wire logic                     I_FRAME_START,
    input  wire logic [CMF_RX_FIFOS-1:0]  I_RX_PUSH,
    input  wire cmf_rx_msg_s              I_RX_MSG,
    output logic [CMF_RX_FIFOS-1:0]       O_RX_READY,
    input  wire logic [CMF_RX_FIFOS-1:0]  I_RX_RELEASE,
    output logic [CMF_RX_FIFOS-1:0][CMF_CNT_W-1:0] O_RX_COUNT,
    output logic [CMF_RX_FIFOS-1:0]       O_RX_OVERRUN,
    output logic                          O_FILTER_CONFIG,
    output logic [CMF_BANKS-1:0]          O_BANK_MATCH_STYLE
);

    // Bus slave

    cmf_bus_e     bus_state_reg;
    cmf_bus_e     bus_state_next;
    logic         bus_req;
    logic         wr_fire;
    logic [3:0]   reg_code;
    logic [31:0]  rd_data;
    logic [31:0]  rd_data_reg;
    logic [31:0]  rd_data_next;
    logic [31:0]  reg_view [CMF_NREGS];

    assign bus_req  = I_WB_CYC & I_WB_STB;
    assign reg_code = cmf_decode(I_WB_ADR);

    // Writes land on the edge where the master sees ack, not before
    assign wr_fire  = bus_req & I_WB_WE & (bus_state_reg == CMF_ACK);

    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            CMF_IDLE: begin
                if (bus_req)
                    bus_state_next = CMF_ACK;
            end
            CMF_ACK: begin
                bus_state_next = CMF_IDLE;
            end
            default: begin
                bus_state_next = CMF_IDLE;
            end
        endcase
    end

    // Unmapped addresses read zero and swallow writes
    assign rd_data = (reg_code < 4'(CMF_NREGS)) ?
                     reg_view[reg_code] : '0;

    assign rd_data_next = (bus_state_reg == CMF_IDLE && bus_req &&
                           !I_WB_WE) ? rd_data : rd_data_reg;

    assign O_WB_ACK = bus_req & (bus_state_reg == CMF_ACK);
    assign O_WB_DAT = rd_data_reg;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            bus_state_reg <= CMF_IDLE;
            rd_data_reg   <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            rd_data_reg   <= rd_data_next;
        end
    end

    // Transmit mailbox upper data words

    logic [CMF_TX_SLOTS-1:0][31:0] tx_word;

    for (genvar t = 0; t < CMF_TX_SLOTS; t++) begin : g_tx
        logic slot_wr;
        logic stamp_on;

        assign slot_wr  = wr_fire && (reg_code == 4'(t));
        assign stamp_on = I_TT_MODE & I_TX_STAMP_EN[t];

        cmf_tx_slot u_slot (
            .i_clk      (I_CLK),
            .i_rst_n    (I_RST_N),
            .i_wr       (slot_wr),
            .i_sel      (I_WB_SEL),
            .i_dat      (I_WB_DAT),
            .i_empty    (I_TX_EMPTY[t]),
            .i_stamp_on (stamp_on),
            .i_stamp    (I_MSG_STAMP[t]),
            .o_word     (tx_word[t]),
            .o_send     (O_TX_DATA_HIGH[t])
        );

        assign reg_view[t] = tx_word[t];
    end

    // Receive side: frame-start stamp and record building

    logic [15:0]  stamp_reg;
    logic [15:0]  stamp_next;
    logic [3:0]   rx_len;
    cmf_rx_rec_s  rx_rec;

    // Capture once per frame; the push at frame end uses the held value
    assign stamp_next = I_FRAME_START ? I_TIMER : stamp_reg;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N)
            stamp_reg <= '0;
        else
            stamp_reg <= stamp_next;
    end

    // Bus codes above eight still carry eight bytes
    assign rx_len = I_RX_MSG.rtr ? 4'h0 :
                    (I_RX_MSG.dlc > CMF_MAX_LEN) ? CMF_MAX_LEN :
                    I_RX_MSG.dlc;

    assign rx_rec.std_id = I_RX_MSG.std_id;
    assign rx_rec.ext_id = I_RX_MSG.ext_id;
    assign rx_rec.ide    = I_RX_MSG.ide;
    assign rx_rec.rtr    = I_RX_MSG.rtr;
    assign rx_rec.stamp  = stamp_reg;
    assign rx_rec.filt   = I_RX_MSG.filt;
    assign rx_rec.len    = rx_len;
    assign rx_rec.data   = I_RX_MSG.data;

    // Receive FIFOs and their read-only mailbox views

    logic [CMF_RX_FIFOS-1:0] ovr_reg;
    logic [CMF_RX_FIFOS-1:0] ovr_next;

    for (genvar f = 0; f < CMF_RX_FIFOS; f++) begin : g_rx
        localparam int BASE = int'(CMF_CODE_RX0) + 4 * f;

        cmf_rx_rec_s   head;
        cmf_rx_rec_s   shown;
        logic          empty;
        cmf_id_word_s  id_word;
        cmf_len_word_s len_word;

        // Only the separate release pops; bus reads never do
        cmf_rx_fifo #(
            .DEPTH (CMF_RX_DEPTH)
        ) u_fifo (
            .i_clk        (I_CLK),
            .i_rst_n      (I_RST_N),
            .i_push_valid (I_RX_PUSH[f]),
            .o_push_ready (O_RX_READY[f]),
            .i_push_data  (rx_rec),
            .i_pop        (I_RX_RELEASE[f]),
            .o_head       (head),
            .o_count      (O_RX_COUNT[f]),
            .o_empty      (empty)
        );

        // An empty FIFO shows zeros rather than stale storage
        assign shown = empty ? '0 : head;

        assign id_word.rx_standard_id = shown.std_id;
        assign id_word.rx_extended_id = shown.ext_id;
        assign id_word.rx_id_format   = shown.ide;
        assign id_word.rx_frame_kind  = shown.rtr;
        assign id_word.rsvd           = 1'b0;

        assign len_word.rx_time_stamp     = shown.stamp;
        assign len_word.rx_matched_filter = shown.filt;
        assign len_word.rsvd              = 4'h0;
        assign len_word.rx_length         = shown.len;

        // No write path reaches these views
        assign reg_view[BASE]     = id_word;
        assign reg_view[BASE + 1] = len_word;
        assign reg_view[BASE + 2] = shown.data[31:0];
        assign reg_view[BASE + 3] = shown.data[63:32];

        // A message arriving at a full FIFO is dropped and flagged
        assign ovr_next[f] = I_RX_PUSH[f] & ~O_RX_READY[f];
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N)
            ovr_reg <= '0;
        else
            ovr_reg <= ovr_next;
    end

    assign O_RX_OVERRUN = ovr_reg;

    // Filter configuration switch and per-bank match style

    logic                 fcs_reg;
    logic                 fcs_next;
    logic [CMF_BANKS-1:0] fmode_reg;
    logic [CMF_BANKS-1:0] fmode_next;
    logic                 fcs_wr;
    logic                 fmode_wr;

    // No hardware event ever touches the switch
    assign fcs_wr   = wr_fire && (reg_code == CMF_CODE_FCTRL) &&
                      I_WB_SEL[0];
    assign fcs_next = fcs_wr ? I_WB_DAT[0] : fcs_reg;

    assign fmode_wr = wr_fire && (reg_code == CMF_CODE_FMODE) &&
                      fcs_reg;

    for (genvar k = 0; k < CMF_BANKS; k++) begin : g_bank
        assign fmode_next[k] = (fmode_wr && I_WB_SEL[k / 8]) ?
                               I_WB_DAT[k] : fmode_reg[k];
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            fcs_reg   <= CMF_FCS_RST;
            fmode_reg <= CMF_FMODE_RST;
        end else begin
            fcs_reg   <= fcs_next;
            fmode_reg <= fmode_next;
        end
    end

    assign reg_view[CMF_CODE_FCTRL] = {CMF_FCTRL_RSVD, fcs_reg};
    assign reg_view[CMF_CODE_FMODE] =
        {{(32 - CMF_BANKS){1'b0}}, fmode_reg};

    // Matching logic reads these; banks are set up only in config mode
    assign O_FILTER_CONFIG    = fcs_reg;
    assign O_BANK_MATCH_STYLE = fmode_reg;

endmodule

// ---- verif/cmf_regs_chk.sv ----
`timescale 1ns/1ps
module cmf_regs_chk
    import cmf_pkg::*;
(
    input wire logic                    I_CLK,
    input wire logic                    I_RST_N,
    input wire logic                    I_WB_CYC,
    input wire logic                    I_WB_STB,
    input wire logic                    I_WB_WE,
    input wire logic [7:0]              I_WB_ADR,
    input wire logic [3:0]              I_WB_SEL,
    input wire logic [31:0]             I_WB_DAT,
    input wire logic                    O_WB_ACK,
    input wire logic [CMF_RX_FIFOS-1:0] I_RX_PUSH,
    input wire logic [CMF_RX_FIFOS-1:0] I_RX_RELEASE,
    input wire logic [CMF_RX_FIFOS-1:0] O_RX_READY,
    input wire logic [CMF_RX_FIFOS-1:0][CMF_CNT_W-1:0] O_RX_COUNT,
    input wire logic [CMF_RX_FIFOS-1:0] O_RX_OVERRUN,
    input wire logic                    O_FILTER_CONFIG,
    input wire logic [CMF_BANKS-1:0]    O_BANK_MATCH_STYLE
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    wire fcs_wr  = O_WB_ACK && I_WB_WE && I_WB_ADR == CMF_OFF_FCTRL
                   && I_WB_SEL[0];
    wire push_ok = I_RX_PUSH[0] && O_RX_READY[0];

    chk_ack_answer: assert property (
        I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK)
        else $error("request not acknowledged");
    chk_ack_single: assert property (
        O_WB_ACK |=> !O_WB_ACK) else $error("ack longer than one cycle");
    chk_fcs_write: assert property (
        fcs_wr |=> O_FILTER_CONFIG == $past(I_WB_DAT[0]))
        else $error("switch did not take written value");
    chk_fcs_hold: assert property (
        !fcs_wr |=> $stable(O_FILTER_CONFIG))
        else $error("switch changed without a write");
    chk_mode_lock: assert property (
        !O_FILTER_CONFIG |=> $stable(O_BANK_MATCH_STYLE))
        else $error("bank style changed while filters active");
    chk_ready_full: assert property (
        O_RX_READY[0] == (O_RX_COUNT[0] != 2'h3))
        else $error("ready disagrees with fifo depth");
    chk_overrun_pulse: assert property (
        I_RX_PUSH[0] && !O_RX_READY[0] |=> O_RX_OVERRUN[0])
        else $error("push into full fifo not flagged");
    chk_count_up: assert property (
        push_ok && !I_RX_RELEASE[0]
        |=> O_RX_COUNT[0] == $past(O_RX_COUNT[0]) + 2'h1)
        else $error("count did not step on push");
    chk_read_pure: assert property (
        O_WB_ACK && !I_RX_PUSH[0] && !I_RX_RELEASE[0]
        |=> $stable(O_RX_COUNT[0]))
        else $error("bus access moved the fifo");

    cover property (I_RX_PUSH[0] && !O_RX_READY[0]);
    cover property (fcs_wr ##1 !O_FILTER_CONFIG);
    cover property (O_RX_COUNT[1] == 2'h3);
endmodule

// ---- verif/cmf_engine_model.sv ----
`timescale 1ns/1ps
module cmf_engine_model
    import cmf_pkg::*;
(
    input  wire logic               i_clk,
    output logic [15:0]             o_timer,
    output logic                    o_frame_start,
    output logic [CMF_RX_FIFOS-1:0] o_push,
    output cmf_rx_msg_s             o_msg
);
    logic [15:0] stamp_reg;

    initial begin
        o_timer       = 16'h0000;
        o_frame_start = 1'b0;
        o_push        = '0;
        o_msg         = '0;
    end

    always @(posedge i_clk) begin
        o_timer <= o_timer + 16'h0001;
        if (o_frame_start) begin
            stamp_reg <= o_timer;
        end
    end

    // Gap of one is the tightest spacing the engine can produce
    task automatic send(input int f, input cmf_rx_msg_s mv,
                        input int gap, output logic [15:0] st);
        @(posedge i_clk);
        o_frame_start <= 1'b1;
        @(posedge i_clk);
        o_frame_start <= 1'b0;
        repeat (gap - 1) @(posedge i_clk);
        o_push[f] <= 1'b1;
        o_msg     <= mv;
        @(posedge i_clk);
        o_push <= '0;
        // Lines are not held after the push; stale data must not match
        o_msg  <= ~mv;
        st = stamp_reg;
    endtask
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin \
    checks_done++; \
    if ((a) !== (e)) begin \
        n_mismatch++; \
        $display("mismatch at %0t: got %h want %h", $time, (a), (e)); \
    end \
end

module testbench
    import cmf_pkg::*;
;
    logic             clk, rst_n, cyc, stb, we, ack, tt, fs, fcfg;
    logic [7:0]       adr, base;
    logic [3:0]       sel;
    logic [31:0]      wdat, rdat, w, q;
    logic [15:0]      timer, st;
    logic [2:0]       tx_empty, stamp_en;
    logic [2:0][15:0] msg_stamp;
    logic [2:0][31:0] txh;
    logic [1:0]       push, rel, ready, ovr;
    logic [1:0][1:0]  count;
    logic [13:0]      bms;
    logic [127:0]     r;
    cmf_rx_msg_s      m, msg;
    cmf_rx_msg_s      q_msg[$];
    logic [15:0]      q_st[$];
    int               n_mismatch, checks_done, i, k, f;

    cmf_regs i_cmf_regs (
        .I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
        .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_TX_EMPTY(tx_empty),
        .I_TT_MODE(tt), .I_TX_STAMP_EN(stamp_en), .I_MSG_STAMP(msg_stamp),
        .O_TX_DATA_HIGH(txh), .I_TIMER(timer), .I_FRAME_START(fs),
        .I_RX_PUSH(push), .I_RX_MSG(msg), .O_RX_READY(ready),
        .I_RX_RELEASE(rel), .O_RX_COUNT(count), .O_RX_OVERRUN(ovr),
        .O_FILTER_CONFIG(fcfg), .O_BANK_MATCH_STYLE(bms)
    );
    cmf_engine_model i_cmf_engine_model (
        .i_clk(clk), .o_timer(timer), .o_frame_start(fs),
        .o_push(push), .o_msg(msg)
    );

    always #2.5 clk = ~clk;

    function automatic logic [31:0] id_word(cmf_rx_msg_s mv);
        return {mv.std_id, mv.ext_id, mv.ide, mv.rtr, 1'b0};
    endfunction

    function automatic logic [3:0] len_of(cmf_rx_msg_s mv);
        if (mv.rtr) begin
            return 4'h0;
        end
        return (mv.dlc > CMF_MAX_LEN) ? CMF_MAX_LEN : mv.dlc;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= wr;
        adr  <= a;
        wdat <= d;
        sel  <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            n_mismatch++;
            $display("mismatch at %0t: bus timeout", $time);
            report_and_stop();
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        wb(1'b0, a, 32'h00000000, 4'hF, v);
        `CHK(v, e)
    endtask

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {cyc, stb, we, tt} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h00000000;
        tx_empty = 3'h7;
        stamp_en = 3'h0;
        msg_stamp = '0;
        rel = 2'h0;
        void'($urandom(32'h0d25));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CHK(fcfg, 1'b1)
        `CHK(bms, 14'h0000)
        rd_chk(CMF_OFF_FCTRL, {CMF_FCTRL_RSVD, CMF_FCS_RST});
        rd_chk(CMF_OFF_FMODE, 32'h00000000);
        rd_chk(8'h3C, 32'h00000000);
        w = $urandom;
        wb(1'b1, CMF_OFF_FMODE, w, 4'h3, q);
        rd_chk(CMF_OFF_FMODE, {18'h00000, w[13:0]});
        wb(1'b1, CMF_OFF_FMODE, ~w, 4'h1, q);
        rd_chk(CMF_OFF_FMODE, {18'h00000, w[13:8], ~w[7:0]});
        w = {18'h00000, w[13:8], ~w[7:0]};
        wb(1'b1, CMF_OFF_FCTRL, 32'h00000000, 4'h1, q);
        // The switch flips on the ack edge itself; look once it has settled
        @(negedge clk);
        `CHK(fcfg, 1'b0)
        wb(1'b1, CMF_OFF_FMODE, ~w, 4'hF, q);
        rd_chk(CMF_OFF_FMODE, w);
        wb(1'b1, CMF_OFF_FCTRL, 32'h00000001, 4'h1, q);
        rd_chk(CMF_OFF_FCTRL, {CMF_FCTRL_RSVD, 1'b1});
        for (k = 0; k < CMF_TX_SLOTS; k++) begin
            base = CMF_OFF_TX0 + 8'(4 * k);
            w = $urandom;
            wb(1'b1, base, w, 4'hF, q);
            rd_chk(base, w);
            tx_empty[k] <= 1'b0;
            wb(1'b1, base, ~w, 4'hF, q);
            rd_chk(base, w);
            `CHK(txh[k], w)
            st = 16'($urandom);
            tt <= 1'b1;
            stamp_en[k] <= 1'b1;
            msg_stamp[k] <= st;
            repeat (3) @(posedge clk);
            `CHK(txh[k], {st[7:0], st[15:8], w[15:0]})
            tt <= 1'b0;
            repeat (3) @(posedge clk);
            `CHK(txh[k], w)
            tx_empty[k] <= 1'b1;
        end
        for (f = 0; f < CMF_RX_FIFOS; f++) begin
            q_msg.delete();
            q_st.delete();
            for (i = 0; i < CMF_RX_DEPTH + 1; i++) begin
                r = {$urandom, $urandom, $urandom, $urandom};
                m = r[$bits(m)-1:0];
                m.rtr = (i == 0);
                if (i < 2) begin
                    m.dlc = (i == 0) ? 4'h5 : 4'hF;
                end
                i_cmf_engine_model.send(f, m, (i == 2) ? 6 : 1, st);
                q_msg.push_back(m);
                q_st.push_back(st);
            end
            @(negedge clk);
            `CHK(count[f], 2'(CMF_RX_DEPTH))
            `CHK(ready[f], 1'b0)
            `CHK(ovr[f], 1'b1)
            base = CMF_OFF_RX0 + 8'(16 * f);
            for (i = 0; i < CMF_RX_DEPTH; i++) begin
                m = q_msg[i];
                rd_chk(base, id_word(m));
                w = {q_st[i], m.filt, 4'h0, len_of(m)};
                rd_chk(base + 8'h04, w);
                rd_chk(base + 8'h08, m.data[31:0]);
                wb(1'b1, base + 8'h0C, ~m.data[63:32], 4'hF, q);
                rd_chk(base + 8'h0C, m.data[63:32]);
                @(posedge clk);
                rel[f] <= 1'b1;
                @(posedge clk);
                rel[f] <= 1'b0;
            end
            @(negedge clk);
            `CHK(count[f], 2'h0)
            `CHK(ovr[f], 1'b0)
        end
        report_and_stop();
    end
endmodule

bind cmf_regs cmf_regs_chk i_cmf_regs_chk (
    .I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
    .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .I_RX_PUSH(I_RX_PUSH), .I_RX_RELEASE(I_RX_RELEASE),
    .O_RX_READY(O_RX_READY), .O_RX_COUNT(O_RX_COUNT),
    .O_RX_OVERRUN(O_RX_OVERRUN), .O_FILTER_CONFIG(O_FILTER_CONFIG),
    .O_BANK_MATCH_STYLE(O_BANK_MATCH_STYLE)
);
